//--- plt_translate_core.sv
// per-channel law translation and per-stream quadrant bit replacement
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Translate both switched channels and message-mode channels alike.
// - High word bit 4 picks voice (0) or data (1) codes.
// - Input coding in high word bits 3-2, output coding in bits 1-0.
// - Voice codes: 00 A-law, 01 mu-law, 10 A-law no ALTERNATE_BIT_INVERSION, 11 mu-law no MI.
// - A-law no-ALTERNATE_BIT_INVERSION leaves even bits 6,4,2,0 uninverted.
// - Mu-law no-MI leaves magnitude bits 6..0 uninverted.
// - Data code 00 passes bits; 01 inverts even bits.
// - Data code 10 inverts odd bits; 11 inverts all bits.
// - Differing selections translate; equal selections pass the byte untouched.
// - One voice/data bit covers both sides; no voice-data translation.
// - Each of 32 input streams splits into four quadrants with optional forcing.
// - A quadrant is one consecutive quarter of the frame's channels, by rate.
// - Quadrant 3..0 controls sit in bits 11-9, 8-6, 5-3, 2-0.
// - Control 0xx normal, 100/101 LSB to 0/1, 110/111 MSB to 0/1.
// - Reset loads all registers except the fifo storage with defaults and clears counters.
module plt_translate_core (
    input wire logic i_clk,
    input wire logic i_rst,
    // microprocessor port
    input wire logic i_cs,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [13:0] i_addr,
    input wire logic [15:0] i_wdata,
    output logic [15:0] o_rdata,
    output logic o_rdata_valid,
    // input channel bytes from the serial receivers
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [4:0] i_in_stream,
    input wire logic [7:0] i_in_chan,
    input wire logic [1:0] i_in_rate,
    input wire logic [7:0] i_in_byte,
    // towards the switching memory
    output logic o_store_valid,
    input wire logic i_store_ready,
    output logic [4:0] o_store_stream,
    output logic [7:0] o_store_chan,
    output logic [7:0] o_store_byte,
    // output channel path
    input wire logic i_out_valid,
    input wire logic i_out_is_msg,
    input wire logic [4:0] i_out_cmh,
    input wire logic [7:0] i_out_byte,
    output logic o_out_valid,
    output logic o_out_is_msg,
    output logic [7:0] o_out_byte
);
    // ----------------------------------------
    // code helpers
    // ----------------------------------------
    function automatic logic [12:0] alaw_mag(input logic [6:0] raw);
        logic [2:0] seg;
        logic [12:0] base;
        seg = raw[6:4];
        base = {7'h00, 1'b1, raw[3:0], 1'b1};
        if (seg == 3'h0) begin
            alaw_mag = {8'h00, raw[3:0], 1'b1};
        end else begin
            alaw_mag = base << (seg - 3'h1);
        end
    endfunction

    function automatic logic [13:0] mu_mag(input logic [6:0] raw);
        logic [14:0] t;
        t = ({8'h00, raw[3:0], 3'h0} + plt_pkg::MU_BIAS) << raw[6:4];
        // bias works on a 16-bit scale, so drop two bits to reach the 14-bit magnitude
        mu_mag = 14'((t - plt_pkg::MU_BIAS) >> 2);
    endfunction

    function automatic logic [6:0] mu_enc(input logic [13:0] mag);
        logic [14:0] v;
        logic [2:0] seg;
        logic [14:0] sh;
        // lift the clipped 14-bit magnitude to the bias scale before the segment search
        v = 15'({((mag > plt_pkg::MU_CLIP) ? plt_pkg::MU_CLIP : mag), 2'b00}) + plt_pkg::MU_BIAS;
        seg = 3'h0;
        for (int i = 1; i < 8; i++) begin
            if (v[i+7]) begin
                seg = 3'(i);
            end
        end
        // shift reaches 10, too wide for the 3-bit segment alone
        sh = v >> (4'(seg) + 4'h3);
        mu_enc = {seg, sh[3:0]};
    endfunction

    function automatic logic [6:0] alaw_enc(input logic [12:0] mag);
        logic [2:0] seg;
        logic [12:0] sh;
        seg = 3'h0;
        for (int i = 1; i < 8; i++) begin
            if (mag[i+4]) begin
                seg = 3'(i);
            end
        end
        sh = (seg == 3'h0) ? (mag >> 1) : (mag >> seg);
        alaw_enc = {seg, sh[3:0]};
    endfunction

    // data inversion mask for a 2-bit selection
    function automatic logic [7:0] data_mask(input logic [1:0] sel);
        case (sel)
            2'b00: data_mask = 8'h00;
            2'b01: data_mask = plt_pkg::EVEN_MASK;
            2'b10: data_mask = plt_pkg::ODD_MASK;
            2'b11: data_mask = plt_pkg::ALL_MASK;
            default: data_mask = 8'h00;
        endcase
    endfunction

    // full translation of one byte under a high connection-memory word
    function automatic logic [7:0] translate(input logic [7:0] b, input logic [4:0] cmh);
        logic [1:0] isel;
        logic [1:0] osel;
        logic [6:0] raw;
        logic [6:0] oraw;
        logic in_mu;
        logic out_mu;
        isel = cmh[plt_pkg::CMH_IN_LSB +: 2];
        osel = cmh[plt_pkg::CMH_OUT_LSB +: 2];
        in_mu = isel[0];
        out_mu = osel[0];
        // sign sits in bit 7 for every voice code, so it is carried through
        case (plt_pkg::plt_code_t'(isel))
            plt_pkg::CODE_A_STD: raw = b[6:0] ^ plt_pkg::EVEN_MASK[6:0];
            plt_pkg::CODE_MU_STD: raw = b[6:0] ^ plt_pkg::MAG_MASK;
            plt_pkg::CODE_A_NOABI: raw = b[6:0];
            plt_pkg::CODE_MU_NOMI: raw = b[6:0];
            default: raw = b[6:0];
        endcase
        if (in_mu == out_mu) begin
            oraw = raw;
        end else if (in_mu) begin
            oraw = alaw_enc(13'(mu_mag(raw) >> 1));
        end else begin
            oraw = mu_enc({alaw_mag(raw), 1'b0});
        end
        if (isel == osel) begin
            translate = b;
        end else if (cmh[plt_pkg::CMH_VD_BIT]) begin
            translate = b ^ data_mask(isel) ^ data_mask(osel);
        end else begin
            case (plt_pkg::plt_code_t'(osel))
                plt_pkg::CODE_A_STD: translate = {b[7], oraw ^ plt_pkg::EVEN_MASK[6:0]};
                plt_pkg::CODE_MU_STD: translate = {b[7], oraw ^ plt_pkg::MAG_MASK};
                plt_pkg::CODE_A_NOABI: translate = {b[7], oraw};
                plt_pkg::CODE_MU_NOMI: translate = {b[7], oraw};
                default: translate = b;
            endcase
        end
    endfunction

    // quadrant index of a channel at the stream's rate
    function automatic logic [1:0] quad_of(input logic [7:0] chan, input logic [1:0] rate);
        case (plt_pkg::plt_rate_t'(rate))
            plt_pkg::RATE_2M: quad_of = chan[4:3];
            plt_pkg::RATE_4M: quad_of = chan[5:4];
            plt_pkg::RATE_8M: quad_of = chan[6:5];
            plt_pkg::RATE_16M: quad_of = chan[7:6];
            default: quad_of = chan[4:3];
        endcase
    endfunction

    // ----------------------------------------
    // quadrant control registers
    // ----------------------------------------
    logic [plt_pkg::QCTL_BITS-1:0] quad_ctrl_q [plt_pkg::NUM_STREAMS];
    logic [15:0] rdata_q;
    logic rdata_valid_q;

    wire [13:0] reg_off = i_addr - plt_pkg::QUAD_REG_BASE;
    wire reg_hit = (i_addr >= plt_pkg::QUAD_REG_BASE) && (reg_off < 14'(plt_pkg::NUM_STREAMS));
    wire [4:0] reg_idx = reg_off[4:0];
    wire reg_wr = i_cs && i_wr && reg_hit;
    wire reg_rd = i_cs && i_rd;
    // unused upper bits and unmapped addresses read as zero
    wire [15:0] rd_word = reg_hit ? {4'h0, quad_ctrl_q[reg_idx]} : 16'h0000;

    always_ff @(posedge i_clk) begin
        for (int s = 0; s < plt_pkg::NUM_STREAMS; s++) begin
            if (i_rst) begin
                quad_ctrl_q[s] <= plt_pkg::QUAD_REG_RESET[plt_pkg::QCTL_BITS-1:0];
            end else if (reg_wr && (reg_idx == 5'(s))) begin
                quad_ctrl_q[s] <= i_wdata[plt_pkg::QCTL_BITS-1:0];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_q <= 16'h0000;
            rdata_valid_q <= 1'b0;
        end else begin
            rdata_q <= reg_rd ? rd_word : rdata_q;
            rdata_valid_q <= reg_rd;
        end
    end

    assign o_rdata = rdata_q;
    assign o_rdata_valid = rdata_valid_q;

    // ----------------------------------------
    // quadrant bit replacement on the input side
    // ----------------------------------------
    // forcing also corrupts the stream's error-rate pattern, so the two may not share a stream
    wire [1:0] in_quad = quad_of(i_in_chan, i_in_rate);
    wire [11:0] in_ctrl_word = quad_ctrl_q[i_in_stream];
    wire [2:0] in_qctl = in_ctrl_word[in_quad*plt_pkg::QCTL_W +: plt_pkg::QCTL_W];
    wire force_val = in_qctl[plt_pkg::QCTL_VAL_BIT];
    wire [7:0] forced_byte = !in_qctl[plt_pkg::QCTL_EN_BIT] ? i_in_byte :
                             in_qctl[plt_pkg::QCTL_MSB_SEL_BIT] ? {force_val, i_in_byte[6:0]} :
                             {i_in_byte[7:1], force_val};
    // forcing ahead of storage means every output picking this channel sees it
    wire [plt_pkg::STORE_W-1:0] store_in = {i_in_stream, i_in_chan, forced_byte};
    wire [plt_pkg::STORE_W-1:0] store_out;
    wire fifo_in_ready;
    wire fifo_out_valid;

    plt_fifo #(
        .WIDTH(plt_pkg::STORE_W),
        .DEPTH(plt_pkg::FIFO_DEPTH)
    ) u_store_fifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_in_valid(i_in_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data(store_in),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(i_store_ready),
        .o_out_data(store_out)
    );

    assign o_in_ready = fifo_in_ready;
    assign o_store_valid = fifo_out_valid;
    assign o_store_stream = store_out[20:16];
    assign o_store_chan = store_out[15:8];
    assign o_store_byte = store_out[7:0];

    // ----------------------------------------
    // output side code translation
    // ----------------------------------------
    // message bytes take the same path as switched bytes; the flag only rides along
    logic out_valid_q;
    logic out_msg_q;
    logic [7:0] out_byte_q;
    wire [7:0] out_xlat = translate(i_out_byte, i_out_cmh);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            out_valid_q <= 1'b0;
            out_msg_q <= 1'b0;
            out_byte_q <= 8'h00;
        end else begin
            out_valid_q <= i_out_valid;
            out_msg_q <= i_out_valid ? i_out_is_msg : out_msg_q;
            out_byte_q <= i_out_valid ? out_xlat : out_byte_q;
        end
    end

    assign o_out_valid = out_valid_q;
    assign o_out_is_msg = out_msg_q;
    assign o_out_byte = out_byte_q;
endmodule
`default_nettype wire

//--- plt_pkg.sv
// shared constants for the law translation and quadrant replacement block
package plt_pkg;
    // ----------------------------------------
    // microprocessor port
    // ----------------------------------------
    localparam int ADDR_W = 14;
    localparam int DATA_W = 16;
    localparam logic [13:0] QUAD_REG_BASE = 14'h0120;
    localparam int NUM_STREAMS = 32;
    localparam logic [15:0] QUAD_REG_RESET = 16'h0000;
    // ----------------------------------------
    // high connection-memory word fields
    // ----------------------------------------
    localparam int CMH_W = 5;
    localparam int CMH_VD_BIT = 4;
    localparam int CMH_IN_LSB = 2;
    localparam int CMH_OUT_LSB = 0;
    // ----------------------------------------
    // quadrant control fields
    // ----------------------------------------
    localparam int QCTL_W = 3;
    localparam int QCTL_BITS = 12;
    localparam int QCTL_EN_BIT = 2;
    localparam int QCTL_MSB_SEL_BIT = 1;
    localparam int QCTL_VAL_BIT = 0;
    // ----------------------------------------
    // coding masks and mu-law bias and clip
    // ----------------------------------------
    localparam logic [7:0] EVEN_MASK = 8'h55;
    localparam logic [7:0] ODD_MASK = 8'haa;
    localparam logic [7:0] ALL_MASK = 8'hff;
    localparam logic [6:0] MAG_MASK = 7'h7f;
    localparam logic [14:0] MU_BIAS = 15'h0084;
    localparam logic [13:0] MU_CLIP = 14'h1fde;
    // ----------------------------------------
    // coding selections, rates and store fifo sizes
    // ----------------------------------------
    typedef enum logic [1:0] {
        CODE_A_STD = 2'b00,
        CODE_MU_STD = 2'b01,
        CODE_A_NOABI = 2'b10,
        CODE_MU_NOMI = 2'b11
    } plt_code_t;
    typedef enum logic [1:0] {
        RATE_2M = 2'b00,
        RATE_4M = 2'b01,
        RATE_8M = 2'b10,
        RATE_16M = 2'b11
    } plt_rate_t;
    localparam int FIFO_DEPTH = 16;
    localparam int STORE_W = 21;
endpackage

//--- plt_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module plt_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic [AW:0] count_d;
    logic full_q;
    logic empty_q;
    wire push = i_in_valid && !full_q;
    wire pop = !empty_q && i_out_ready;

    assign count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
    assign o_in_ready = !full_q;
    assign o_out_valid = !empty_q;
    assign o_out_data = mem_q[rd_ptr_q];

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            full_q <= 1'b0;
            empty_q <= 1'b1;
        end else begin
            wr_ptr_q <= push ? wr_ptr_q + AW'(1) : wr_ptr_q;
            rd_ptr_q <= pop ? rd_ptr_q + AW'(1) : rd_ptr_q;
            count_q <= count_d;
            full_q <= (count_d == (AW+1)'(DEPTH));
            empty_q <= (count_d == '0);
        end
    end
endmodule
`default_nettype wire

//--- plt_chk_sva.sv
// port assertions for the translate core
`timescale 1ns/1ns
`default_nettype none
module plt_chk (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_cs,
    input wire logic i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic o_rdata_valid,
    input wire logic o_in_ready,
    input wire logic o_store_valid,
    input wire logic i_store_ready,
    input wire logic [7:0] o_store_byte,
    input wire logic i_out_valid,
    input wire logic i_out_is_msg,
    input wire logic [4:0] i_out_cmh,
    input wire logic [7:0] i_out_byte,
    input wire logic o_out_valid,
    input wire logic o_out_is_msg,
    input wire logic [7:0] o_out_byte
);
    // ----
    // expected bytes
    // ----
    function automatic logic [7:0] dm(input logic [1:0] c);
        return (c == 2'b01) ? 8'h55 : (c == 2'b10) ? 8'haa : {8{c == 2'b11}};
    endfunction
    wire logic [7:0] dexp = i_out_byte ^ dm(i_out_cmh[3:2]) ^ dm(i_out_cmh[1:0]);
    wire logic [7:0] vexp = i_out_byte ^ (i_out_cmh[2] ? 8'h7f : 8'h55);
    wire logic same_law = (i_out_cmh[3:2] ^ i_out_cmh[1:0]) == 2'b10;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_rd;
        i_cs && i_rd;
    endsequence
    sequence s_tr;
        i_out_valid;
    endsequence
    property p_rd_ans;
        s_rd |=> o_rdata_valid && o_rdata[15:12] == 4'h0;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer wrong");
    property p_rd_quiet;
        !(i_cs && i_rd) |=> !o_rdata_valid;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("spurious read answer");
    property p_tr_lat;
        s_tr |=> o_out_valid && o_out_is_msg == $past(i_out_is_msg);
    endproperty
    a_tr_lat: assert property (p_tr_lat) else $error("translate answer late");
    property p_tr_quiet;
        !i_out_valid |=> !o_out_valid && $stable(o_out_byte);
    endproperty
    a_tr_quiet: assert property (p_tr_quiet) else $error("spurious translate");
    property p_same;
        s_tr and (i_out_cmh[3:2] == i_out_cmh[1:0]) |=> o_out_byte == $past(i_out_byte);
    endproperty
    a_same: assert property (p_same) else $error("equal codes altered byte");
    property p_data;
        s_tr and i_out_cmh[4] |=> o_out_byte == $past(dexp);
    endproperty
    a_data: assert property (p_data) else $error("data code wrong");
    property p_voice;
        s_tr and (!i_out_cmh[4] && same_law) |=> o_out_byte == $past(vexp);
    endproperty
    a_voice: assert property (p_voice) else $error("voice variant wrong");
    property p_rst;
        disable iff (1'b0) i_rst |=> !o_out_valid && !o_store_valid && o_in_ready && !o_rdata_valid;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_hold;
        o_store_valid && !i_store_ready |=> o_store_valid && $stable(o_store_byte);
    endproperty
    a_hold: assert property (p_hold) else $error("store head dropped");
endmodule
bind plt_translate_core plt_chk u_plt_chk (.*);
`default_nettype wire

//--- plt_far.sv
// far side model: channel byte source and switching memory sink
`timescale 1ns/1ns
`default_nettype none
module plt_far (
    input wire logic i_clk,
    input wire logic i_hold,
    input wire logic i_in_ready,
    input wire logic i_store_valid,
    input wire logic [20:0] i_store_word,
    output logic o_in_valid,
    output logic [4:0] o_in_stream,
    output logic [7:0] o_in_chan,
    output logic [1:0] o_in_rate,
    output logic [7:0] o_in_byte,
    output logic o_store_ready
);
    logic [20:0] got [$];
    logic [3:0] pace = 4'h5;
    initial begin
        {o_in_valid, o_in_stream, o_in_chan, o_in_rate, o_in_byte, o_store_ready} = 25'h0;
    end
    // sink stalls on its own pattern so the fifo sees slow takers too
    always @(negedge i_clk) begin
        pace <= {pace[2:0], pace[3] ^ pace[2]};
        o_store_ready <= !i_hold && pace[0];
    end
    always @(posedge i_clk) begin
        if (i_store_valid && o_store_ready) begin
            got.push_back(i_store_word);
        end
    end
    task automatic send(input logic [4:0] s, input logic [7:0] c, input logic [1:0] r,
                        input logic [7:0] b, output logic ok);
        int n;
        n = 0;
        @(negedge i_clk);
        {o_in_valid, o_in_stream, o_in_chan, o_in_rate, o_in_byte} = {1'b1, s, c, r, b};
        while (!i_in_ready && n < 64) begin
            @(negedge i_clk);
            n++;
        end
        @(negedge i_clk);
        ok = n < 64;
        // idle channel and byte lines toggle so stale data is never mistaken for a byte
        {o_in_valid, o_in_chan, o_in_byte} = {1'b0, ~c, ~b};
    endtask
endmodule
`default_nettype wire

//--- tb_plt_translate_core.sv
// self-checking bench for the translate core
`timescale 1ns/1ns
`default_nettype none
module tb_plt_translate_core;
    logic i_clk = 0, i_rst = 1, i_cs = 0, i_wr = 0, i_rd = 0, i_out_valid = 0, i_out_is_msg = 0;
    logic hold = 0, ok, o_rdata_valid, i_in_valid, o_in_ready, o_store_valid, i_store_ready;
    logic o_out_valid, o_out_is_msg;
    logic [13:0] i_addr = 14'h0000;
    logic [15:0] i_wdata = 16'h0000, o_rdata;
    logic [4:0] i_in_stream, o_store_stream, i_out_cmh = 5'h00, m;
    logic [7:0] i_in_chan, i_in_byte, o_store_chan, o_store_byte, i_out_byte = 8'h00, o_out_byte, c;
    logic [1:0] i_in_rate;
    logic [31:0] seed = 32'hc341;
    logic [11:0] ctl [32];
    logic [20:0] expq [$];
    int n_errors = 0, n_compared = 0;
    always #50 i_clk = ~i_clk;
    plt_translate_core u_plt_translate_core (.*);
    plt_far u_plt_far (.i_clk(i_clk), .i_hold(hold), .i_in_ready(o_in_ready), .i_store_valid(o_store_valid),
        .i_store_word({o_store_stream, o_store_chan, o_store_byte}), .o_in_valid(i_in_valid),
        .o_in_stream(i_in_stream), .o_in_chan(i_in_chan), .o_in_rate(i_in_rate), .o_in_byte(i_in_byte),
        .o_store_ready(i_store_ready));
    // ----
    // expectations
    // ----
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [7:0] qexp(input logic [11:0] q, input logic [7:0] ch, input logic [1:0] r,
                                        input logic [7:0] b);
        logic [11:0] t;
        t = q >> (3 * ((ch >> (3 + r)) & 8'h03));
        if (t[2] && t[1]) b[7] = t[0];
        else if (t[2]) b[0] = t[0];
        return b;
    endfunction
    function automatic logic [7:0] dm(input logic [1:0] k);
        return (k == 2'b01) ? 8'h55 : (k == 2'b10) ? 8'haa : {8{k == 2'b11}};
    endfunction
    function automatic logic [7:0] texp(input logic [4:0] k, input logic [7:0] b);
        if (k[3:2] == k[1:0]) return b;
        if (k[4]) return b ^ dm(k[3:2]) ^ dm(k[1:0]);
        return b ^ (k[2] ? 8'h7f : 8'h55);
    endfunction
    // ----
    // checks and port tasks
    // ----
    task automatic chk(input string nm, input logic [20:0] got, input logic [20:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    task automatic conclude();
        if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [4:0] s, input logic [15:0] d, input logic [13:0] a = 14'h0120);
        @(negedge i_clk);
        {i_cs, i_wr, i_addr, i_wdata} = {2'b11, a + 14'(s), d};
        @(negedge i_clk);
        {i_cs, i_wr} = 2'b00;
    endtask
    task automatic rd(input logic [4:0] s, input logic [15:0] e, input logic [13:0] a = 14'h0120);
        @(negedge i_clk);
        {i_cs, i_rd, i_addr} = {2'b11, a + 14'(s)};
        @(negedge i_clk);
        {i_cs, i_rd} = 2'b00;
        chk("rdata_valid", o_rdata_valid, 1);
        chk("rdata", o_rdata, e);
    endtask
    task automatic push(input logic [4:0] s, input logic [7:0] ch, input logic [1:0] r, input logic [7:0] b);
        u_plt_far.send(s, ch, r, b, ok);
        chk("in_ready wait", ok, 1);
        if (!ok) conclude();
        expq.push_back({s, ch, qexp(ctl[s], ch, r, b)});
    endtask
    task automatic drain();
        int n;
        n = 0;
        while (u_plt_far.got.size() < expq.size() && n < 500) begin
            @(negedge i_clk);
            n++;
        end
        chk("drain", n < 500, 1);
        if (n == 500) conclude();
        while (expq.size() > 0) chk("store word", u_plt_far.got.pop_front(), expq.pop_front());
    endtask
    task automatic tr(input logic [4:0] k, input logic [7:0] b, input logic [7:0] e);
        @(negedge i_clk);
        {i_out_valid, i_out_is_msg, i_out_cmh, i_out_byte} = {1'b1, b[0] ^ k[0], k, b};
        @(negedge i_clk);
        i_out_valid = 0;
        chk("out_valid", o_out_valid, 1);
        chk("out_msg", o_out_is_msg, b[0] ^ k[0]);
        chk("out_byte", o_out_byte, e);
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        for (int s = 0; s < 32; s++) ctl[s] = 12'h000;
        repeat (4) @(negedge i_clk);
        i_rst = 0;
        for (int s = 0; s < 32; s++) rd(5'(s), 16'h0000);
        wr(5'h1f, 16'hffff, 14'h0100);
        wr(5'h00, 16'hffff, 14'h0140);
        rd(5'h1f, 16'h0000, 14'h0100);
        rd(5'h00, 16'h0000, 14'h0140);
        rd(5'h1f, 16'h0000);
        rd(5'h00, 16'h0000);
        for (int s = 0; s < 32; s++) begin
            seed = lfsr(seed);
            ctl[s] = seed[11:0];
            wr(5'(s), seed[15:0]);
        end
        for (int s = 0; s < 32; s++) rd(5'(s), {4'h0, ctl[s]});
        // every control code loaded into all quadrants of stream 3, four pushes each at its own random rate, quadrant bits q ORed with random bits
        for (int k = 0; k < 8; k++) begin
            ctl[3] = {4{3'(k)}};
            wr(5'h03, {4'h0, ctl[3]});
            for (int q = 0; q < 4; q++) begin
                seed = lfsr(seed);
                c = (seed[7:0] & (8'hff >> (2'h3 - seed[9:8]))) | (8'(q) << (3 + seed[9:8]));
                push(5'h03, c, seed[9:8], seed[17:10]);
            end
        end
        for (int k = 0; k < 60; k++) begin
            seed = lfsr(seed);
            push(seed[4:0], seed[12:5] & (8'hff >> (2'h3 - seed[14:13])), seed[14:13], seed[22:15]);
        end
        drain();
        // sink stalls until the fifo refuses, then empties it
        hold = 1;
        repeat (2) @(negedge i_clk);
        for (int k = 0; k < 16; k++) push(5'h03, 8'(k), 2'h0, 8'h00);
        @(negedge i_clk);
        chk("in_ready full", o_in_ready, 0);
        hold = 0;
        drain();
        repeat (2) @(negedge i_clk);
        chk("store empty", o_store_valid, 0);
        tr(5'b0_00_01, 8'hd5, 8'hfe);
        tr(5'b0_01_00, 8'hff, 8'hd5);
        // top segments on both sides
        tr(5'b0_00_01, 8'haa, 8'h80);
        tr(5'b0_01_00, 8'h80, 8'haa);
        for (int k = 0; k < 100; k++) begin
            seed = lfsr(seed);
            m = seed[4:0];
            if (!m[4]) m[1:0] = {seed[5], m[2]};
            tr(m, seed[15:8], texp(m, seed[15:8]));
        end
        conclude();
    end
endmodule
`default_nettype wire
